//--- core/uec_pkg.sv
package uec_pkg;
    // ------------------------------------------------------------
    // indirect register indices
    // ------------------------------------------------------------
    localparam logic [5:0] A_IN_L  = 6'h11;
    localparam logic [5:0] A_IN_H  = 6'h12;
    localparam logic [5:0] A_OUT_L = 6'h14;
    localparam logic [5:0] A_OUT_H = 6'h15;
    localparam logic [5:0] A_CNT_L = 6'h16;
    localparam logic [5:0] A_CNT_H = 6'h17;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_IN_PACKET_READY = 0;
    localparam int B_IN_FIFO_NONEMPTY = 1;
    localparam int B_IN_UNDERRUN_FLAG = 2;
    localparam int B_FLUSH  = 3;
    localparam int B_SEND_STALL  = 4;
    localparam int B_STALL_SENT_FLAG  = 5;
    localparam int B_ICLRDT = 6;
    localparam int B_ISO_UPDATE_DEFER  = 0;
    localparam int B_SPLIT  = 2;
    localparam int B_FORCE_TOGGLE_EVERY_PACKET   = 3;
    localparam int B_ENDPOINT_DIRECTION_SELECT = 5;
    localparam int B_ISO    = 6;
    localparam int B_DBL    = 7;
    localparam int B_OUT_PACKET_READY  = 0;
    localparam int B_OFULL  = 1;
    localparam int B_OUT_OVERRUN_FLAG  = 2;
    localparam int B_OUT_DATA_ERROR_FLAG = 3;
    localparam int B_OFLUSH = 4;
    localparam int B_OSDSTL = 5;
    localparam int B_OSTSTL = 6;
    localparam int B_OCLRDT = 7;
    localparam int CNT_W    = 10;
    localparam int SLOT_W   = 2;
    // ------------------------------------------------------------
    // handshake codes toward the serial engine
    // ------------------------------------------------------------
    localparam logic [2:0] R_ACK   = 3'h1;
    localparam logic [2:0] R_NAK   = 3'h2;
    localparam logic [2:0] R_STALL = 3'h3;
    localparam logic [2:0] R_DATA  = 3'h4;
    localparam logic [2:0] R_ZLP   = 3'h5;
    // ------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic       adr_we;
        logic       dat_we;
        logic [7:0] wdata;
    } uec_fw_req_t;
    typedef struct packed {
        logic             in_token;
        logic             in_tx_end;
        logic             in_acked;
        logic             out_end;
        logic             out_err;
        logic             sof;
        logic [CNT_W-1:0] out_len;
    } uec_lnk_ev_t;
    typedef struct packed {
        logic       valid;
        logic [2:0] code;
        logic       toggle;
    } uec_resp_t;
    typedef struct packed {logic [SLOT_W-1:0] cnt;} uec_slot_st_t;
    typedef struct packed {logic tog;} uec_tog_st_t;
    typedef struct packed {
        logic [5:0]       idx;
        logic             dbl_in;
        logic             iso_in;
        logic             endpoint_direction_select;
        logic             force_toggle_every_packet;
        logic             split;
        logic             iso_update_defer;
        logic             flush;
        logic             underrun;
        logic             in_send_stall;
        logic             in_stall_sent_flag;
        logic             defer;
        logic             dbl_out;
        logic             iso_out;
        logic             out_send_stall;
        logic             out_stall_sent_flag;
        logic             overrun;
        logic             out_data_error_flag;
        logic [CNT_W-1:0] out_len;
        logic [7:0]       rdata;
        uec_resp_t        resp;
    } uec_st_t;
endpackage

//--- core/uec_slots.sv
`timescale 1ns/1ps
// packet slot counter for one endpoint fifo
module uec_slots #(
    parameter int MAX_PKTS = 2
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       push,
    input  wire logic                       pop,
    input  wire logic                       dbl,
    output logic [uec_pkg::SLOT_W-1:0]      cnt,
    output logic                            full
);
    uec_pkg::uec_slot_st_t st_r;
    uec_pkg::uec_slot_st_t st_nxt;
    logic [uec_pkg::SLOT_W-1:0] cap;

    // one slot unless doubled; caller never pushes when full
    always_comb begin
        cap = dbl ? uec_pkg::SLOT_W'(MAX_PKTS) : uec_pkg::SLOT_W'(1);
        st_nxt = st_r;
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + uec_pkg::SLOT_W'(1);
        end else if (pop && !push && st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - uec_pkg::SLOT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cnt  = st_r.cnt;
    assign full = (st_r.cnt >= cap);
endmodule

//--- core/uec_toggle.sv
`timescale 1ns/1ps
// data toggle bit, clear beats advance
module uec_toggle (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clr,
    input  wire logic adv,
    output logic      tog
);
    uec_pkg::uec_tog_st_t st_r;
    uec_pkg::uec_tog_st_t st_nxt;

    // firmware clear resynchronises with the host, so it wins
    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.tog = 1'b0;
        end else if (adv) begin
            st_nxt.tog = ~st_r.tog;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tog = st_r.tog;
endmodule

//--- core/uec_top.sv
`timescale 1ns/1ps
module uec_top (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire uec_pkg::uec_fw_req_t FW_REQ,
    output logic [7:0]                FW_RDATA,
    input  wire uec_pkg::uec_lnk_ev_t LNK_EV,
    output uec_pkg::uec_resp_t        RESP
);
    uec_pkg::uec_st_t st_r;
    uec_pkg::uec_st_t st_nxt;

    logic [uec_pkg::SLOT_W-1:0] in_cnt;
    logic [uec_pkg::SLOT_W-1:0] out_cnt;
    logic                       in_full;
    logic                       out_full;
    logic                       in_tog;
    logic                       out_tog;
    logic                       in_push;
    logic                       in_pop;
    logic                       out_push;
    logic                       out_pop;
    logic                       in_adv;
    logic                       in_clr;
    logic                       out_clr;
    logic                       wr_inl;
    logic                       wr_inh;
    logic                       wr_outl;
    logic                       wr_outh;
    logic                       in_packet_ready_vis;
    logic                       stall_in;
    logic [7:0]                 wd;

    // ------------------------------------------------------------
    // fifo bookkeeping and toggles
    // ------------------------------------------------------------
    uec_slots #(
        .MAX_PKTS (2)
    ) u_in_slots (
        .clk   (CLK),
        .rst_n (RST_N),
        .push  (in_push),
        .pop   (in_pop),
        .dbl   (st_r.dbl_in),
        .cnt   (in_cnt),
        .full  (in_full)
    );

    uec_slots #(
        .MAX_PKTS (2)
    ) u_out_slots (
        .clk   (CLK),
        .rst_n (RST_N),
        .push  (out_push),
        .pop   (out_pop),
        .dbl   (st_r.dbl_out),
        .cnt   (out_cnt),
        .full  (out_full)
    );

    uec_toggle u_in_tog (
        .clk   (CLK),
        .rst_n (RST_N),
        .clr   (in_clr),
        .adv   (in_adv),
        .tog   (in_tog)
    );

    uec_toggle u_out_tog (
        .clk   (CLK),
        .rst_n (RST_N),
        .clr   (out_clr),
        .adv   (out_push && !st_r.iso_out),
        .tog   (out_tog)
    );

    // ------------------------------------------------------------
    // indirect decode, only through the data port at the held index
    // ------------------------------------------------------------
    always_comb begin
        wd      = FW_REQ.wdata;
        wr_inl  = FW_REQ.dat_we && (st_r.idx == uec_pkg::A_IN_L);
        wr_inh  = FW_REQ.dat_we && (st_r.idx == uec_pkg::A_IN_H);
        wr_outl = FW_REQ.dat_we && (st_r.idx == uec_pkg::A_OUT_L);
        wr_outh = FW_REQ.dat_we && (st_r.idx == uec_pkg::A_OUT_H);
        in_clr  = wr_inl && wd[uec_pkg::B_ICLRDT];
        out_clr = wr_outl && wd[uec_pkg::B_OCLRDT];
    end

    // stall only acts in bulk/interrupt mode
    assign stall_in = st_r.in_send_stall && !st_r.iso_in;

    // ------------------------------------------------------------
    // fifo strobes
    // ------------------------------------------------------------
    always_comb begin
        in_push = wr_inl && wd[uec_pkg::B_IN_PACKET_READY] && !in_full;
        // one packet per flush write, a stall also drops the head
        in_pop  = (wr_inl && wd[uec_pkg::B_FLUSH])
               || LNK_EV.in_tx_end
               || (LNK_EV.in_token && stall_in);
        // force mode advances even on a lost ACK
        in_adv  = LNK_EV.in_tx_end
               && (LNK_EV.in_acked || st_r.force_toggle_every_packet);
        out_push = LNK_EV.out_end && !LNK_EV.in_token && !out_full
                && !(st_r.out_send_stall && !st_r.iso_out);
        // writing zero to OUT ready hands the head packet back
        out_pop  = wr_outl && (out_cnt != '0)
                && (!wd[uec_pkg::B_OUT_PACKET_READY] || wd[uec_pkg::B_OFLUSH]);
    end

    // packet ready: held while queued, dropped early when a slot is open
    always_comb begin
        if (st_r.dbl_in) begin
            in_packet_ready_vis = (in_cnt == uec_pkg::SLOT_W'(2));
        end else begin
            in_packet_ready_vis = (in_cnt != '0);
        end
        if (st_r.defer) begin
            in_packet_ready_vis = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next state: registers, sticky flags, answers, read data
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.resp = '0;
        if (FW_REQ.adr_we) begin
            st_nxt.idx = FW_REQ.wdata[5:0];
        end
        // control bits
        if (wr_inh) begin
            st_nxt.dbl_in = wd[uec_pkg::B_DBL];
            st_nxt.iso_in = wd[uec_pkg::B_ISO];
            st_nxt.endpoint_direction_select = wd[uec_pkg::B_ENDPOINT_DIRECTION_SELECT];
            st_nxt.force_toggle_every_packet   = wd[uec_pkg::B_FORCE_TOGGLE_EVERY_PACKET];
            st_nxt.split  = wd[uec_pkg::B_SPLIT];
            st_nxt.iso_update_defer  = wd[uec_pkg::B_ISO_UPDATE_DEFER];
        end
        if (wr_outh) begin
            st_nxt.dbl_out = wd[uec_pkg::B_DBL];
            st_nxt.iso_out = wd[uec_pkg::B_ISO];
        end
        if (wr_inl) begin
            st_nxt.in_send_stall = wd[uec_pkg::B_SEND_STALL];
        end
        if (wr_outl) begin
            st_nxt.out_send_stall = wd[uec_pkg::B_OSDSTL];
        end
        // flush bit is seen for one cycle then falls back by itself
        st_nxt.flush = wr_inl && wd[uec_pkg::B_FLUSH];
        // sticky flags: a write of zero clears, a same-cycle set wins
        if (wr_inl) begin
            st_nxt.underrun = st_r.underrun && wd[uec_pkg::B_IN_UNDERRUN_FLAG];
            st_nxt.in_stall_sent_flag = st_r.in_stall_sent_flag && wd[uec_pkg::B_STALL_SENT_FLAG];
        end
        if (wr_outl) begin
            st_nxt.overrun   = st_r.overrun && wd[uec_pkg::B_OUT_OVERRUN_FLAG];
            st_nxt.out_stall_sent_flag = st_r.out_stall_sent_flag && wd[uec_pkg::B_OSTSTL];
        end
        // deferred iso packet stays hidden until the frame marker
        if (LNK_EV.sof) begin
            st_nxt.defer = 1'b0;
        end
        if (in_push && st_r.iso_in && st_r.iso_update_defer) begin
            st_nxt.defer = 1'b1;
        end
        // IN token answer
        if (LNK_EV.in_token) begin
            st_nxt.resp.valid  = 1'b1;
            st_nxt.resp.toggle = in_tog;
            if (stall_in) begin
                st_nxt.resp.code = uec_pkg::R_STALL;
                st_nxt.in_stall_sent_flag  = 1'b1;
            end else if (in_cnt != '0 && !st_r.defer) begin
                st_nxt.resp.code = uec_pkg::R_DATA;
            end else if (st_r.iso_in) begin
                st_nxt.resp.code = uec_pkg::R_ZLP;
                st_nxt.underrun  = 1'b1;
            end else begin
                st_nxt.resp.code = uec_pkg::R_NAK;
                st_nxt.underrun  = 1'b1;
            end
        end else if (LNK_EV.out_end) begin
            // OUT packet end; iso gets no handshake
            st_nxt.resp.valid  = !st_r.iso_out;
            st_nxt.resp.toggle = out_tog;
            if (st_r.out_send_stall && !st_r.iso_out) begin
                st_nxt.resp.code = uec_pkg::R_STALL;
                st_nxt.out_stall_sent_flag = 1'b1;
            end else if (out_full) begin
                st_nxt.resp.code = uec_pkg::R_NAK;
                st_nxt.overrun   = 1'b1;
            end else begin
                st_nxt.resp.code = uec_pkg::R_ACK;
                st_nxt.out_len   = LNK_EV.out_len;
                st_nxt.out_data_error_flag    = st_r.iso_out && LNK_EV.out_err;
            end
        end
        // read data follows the index one cycle later
        case (st_r.idx)
            uec_pkg::A_IN_L: begin
                st_nxt.rdata = {2'b00, st_r.in_stall_sent_flag, st_r.in_send_stall,
                                st_r.flush, st_r.underrun,
                                (in_cnt != '0), in_packet_ready_vis};
            end
            uec_pkg::A_IN_H: begin
                st_nxt.rdata = {st_r.dbl_in, st_r.iso_in, st_r.endpoint_direction_select,
                                1'b0, st_r.force_toggle_every_packet, st_r.split,
                                1'b0, st_r.iso_update_defer};
            end
            uec_pkg::A_OUT_L: begin
                st_nxt.rdata = {1'b0, st_r.out_stall_sent_flag, st_r.out_send_stall,
                                1'b0, st_r.out_data_error_flag, st_r.overrun,
                                out_full, (out_cnt != '0)};
            end
            uec_pkg::A_OUT_H: begin
                st_nxt.rdata = {st_r.dbl_out, st_r.iso_out, 6'h00};
            end
            uec_pkg::A_CNT_L: begin
                st_nxt.rdata = st_r.out_len[7:0];
            end
            uec_pkg::A_CNT_H: begin
                st_nxt.rdata = {6'h00, st_r.out_len[9:8]};
            end
            default: begin
                st_nxt.rdata = uec_pkg::RST_BYTE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign FW_RDATA = st_r.rdata;
    assign RESP     = st_r.resp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // a second flush write straight after the first is a new operation, not a stuck bit
    a_flush_self_clear: assert property (
        st_r.flush && !(wr_inl && wd[uec_pkg::B_FLUSH]) |=> !st_r.flush)
        else $error("flush bit did not fall back");
    a_flush_drops_one: assert property (
        (wr_inl && wd[uec_pkg::B_FLUSH] && !in_push && in_cnt == 2'd1)
        |=> in_cnt == 2'd0 && !in_packet_ready_vis)
        else $error("flush kept the packet");
    a_iso_underrun: assert property (
        (LNK_EV.in_token && st_r.iso_in && !stall_in && in_cnt == 2'd0)
        |=> RESP.valid && RESP.code == uec_pkg::R_ZLP && st_r.underrun)
        else $error("iso underrun missed");
    a_bulk_underrun: assert property (
        (LNK_EV.in_token && !st_r.iso_in && !stall_in && in_cnt == 2'd0)
        |=> RESP.code == uec_pkg::R_NAK && st_r.underrun)
        else $error("bulk NAK without underrun");
    a_ready_on_tx: assert property (
        (LNK_EV.in_tx_end && !in_push && in_cnt == 2'd1
         && st_r.idx == uec_pkg::A_IN_L && !FW_REQ.adr_we)
        |=> !in_packet_ready_vis ##1 st_r.rdata[uec_pkg::B_IN_PACKET_READY] == 1'b0)
        else $error("packet ready stuck after transmit");
    a_defer_until_sof: assert property (
        st_r.defer && !LNK_EV.sof |=> st_r.defer && !in_packet_ready_vis)
        else $error("deferred ready shown early");
    a_toggle_on_ack: assert property (
        (LNK_EV.in_tx_end && !st_r.force_toggle_every_packet && !LNK_EV.in_acked && !in_clr)
        |=> in_tog == $past(in_tog))
        else $error("toggle moved without ACK");
    a_toggle_forced: assert property (
        (LNK_EV.in_tx_end && st_r.force_toggle_every_packet && !in_clr)
        |=> in_tog != $past(in_tog))
        else $error("forced toggle did not move");
    a_count_split: assert property (
        (out_push && st_r.idx == uec_pkg::A_CNT_H && !FW_REQ.adr_we)
        |=> ##1 FW_RDATA == {6'h00, $past(LNK_EV.out_len[9:8], 2)})
        else $error("count high wrong");
    a_count_low: assert property (
        (out_push && st_r.idx == uec_pkg::A_CNT_L && !FW_REQ.adr_we)
        |=> ##1 FW_RDATA == $past(LNK_EV.out_len[7:0], 2))
        else $error("count low wrong");
    // iso packets are stored even when damaged, the flag tells firmware
    a_out_data_error_flag_iso: assert property (
        (LNK_EV.out_end && !LNK_EV.in_token && st_r.iso_out && !out_full)
        |=> st_r.out_data_error_flag == $past(LNK_EV.out_err))
        else $error("data error flag wrong");
    a_overrun_set: assert property (
        (LNK_EV.out_end && !LNK_EV.in_token && out_full
         && !(st_r.out_send_stall && !st_r.iso_out))
        |=> st_r.overrun ##1 (st_r.overrun || $past(wr_outl && !wd[uec_pkg::B_OUT_OVERRUN_FLAG])))
        else $error("overrun not sticky");
    a_stall_flag: assert property (
        (LNK_EV.in_token && stall_in)
        |=> RESP.code == uec_pkg::R_STALL && st_r.in_stall_sent_flag)
        else $error("stall not flagged");

    c_in_data: cover property (RESP.valid && RESP.code == uec_pkg::R_DATA);
    c_out_two: cover property (out_cnt == 2'd2);
    c_iso_zlp: cover property (RESP.code == uec_pkg::R_ZLP ##1 LNK_EV.sof);
    c_out_stall: cover property (RESP.valid && RESP.code == uec_pkg::R_STALL
                                 && st_r.out_stall_sent_flag);
endmodule

//--- bench/uec_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// token source standing in for the host on the bus
// ----------------------------------------------------------------
module uec_host (
    input  wire logic            CLK,
    output uec_pkg::uec_lnk_ev_t EV
);
    uec_pkg::uec_lnk_ev_t e;
    initial EV = '0;
    // one-cycle event after slow+1 idle cycles; the length bus is scrambled
    // afterwards so a design that keeps sampling it sees garbage
    task automatic send(input uec_pkg::uec_lnk_ev_t v, input int slow);
        repeat (slow) @(negedge CLK);
        @(negedge CLK);
        EV = v;
        @(negedge CLK);
        e = '0;
        e.out_len = ~v.out_len;
        EV = e;
    endtask
    task automatic in_tok(input int slow);
        send('{in_token: 1'b1, default: '0}, slow);
    endtask
    task automatic tx_end(input logic ack);
        send('{in_tx_end: 1'b1, in_acked: ack, default: '0}, 0);
    endtask
    task automatic out_pkt(input logic [9:0] len, input logic err);
        send('{out_end: 1'b1, out_len: len, out_err: err, default: '0}, 2);
    endtask
    task automatic sof();
        send('{sof: 1'b1, default: '0}, 1);
    endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    logic                 CLK;
    logic                 RST_N;
    uec_pkg::uec_fw_req_t FW_REQ;
    logic [7:0]           FW_RDATA;
    uec_pkg::uec_lnk_ev_t LNK_EV;
    uec_pkg::uec_resp_t   RESP;
    logic [2:0]           rc;
    logic                 rt;
    logic [4:0]           nr;
    int                   error_cnt;
    int                   comparisons;
    initial CLK = 1'b0;
    always #25 CLK = ~CLK;
    uec_top uut (
        .CLK      (CLK),
        .RST_N    (RST_N),
        .FW_REQ   (FW_REQ),
        .FW_RDATA (FW_RDATA),
        .LNK_EV   (LNK_EV),
        .RESP     (RESP)
    );
    uec_host host (
        .CLK (CLK),
        .EV  (LNK_EV)
    );
    // last answer and a count, so a missing or doubled answer shows
    always @(posedge CLK) begin
        if (RST_N !== 1'b1) begin
            nr <= '0;
            rc <= '0;
        end else if (RESP.valid === 1'b1) begin
            nr <= nr + 5'h1;
            rc <= RESP.code;
            rt <= RESP.toggle;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        comparisons++;
        if (g !== x) begin
            $display("mismatch %s expected %h seen %h", nm, x, g);
            error_cnt++;
        end
    endtask
    // index load, then data strobe at the held index
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge CLK);
        FW_REQ = {2'b10, 2'b00, a};
        @(negedge CLK);
        FW_REQ = {2'b01, d};
        @(negedge CLK);
        FW_REQ = '0;
    endtask
    // read data trails the index load by two edges; one more for margin
    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        @(negedge CLK);
        FW_REQ = {2'b10, 2'b00, a};
        @(negedge CLK);
        FW_REQ = '0;
        repeat (2) @(negedge CLK);
        chk($sformatf("reg %h", a), x, FW_RDATA);
    endtask
    task automatic rsp(input logic [4:0] n, input logic [2:0] c);
        repeat (3) @(negedge CLK);
        chk("answer", {n, c}, {nr, rc});
    endtask
    task automatic tok(input logic [2:0] c, input int slow);
        logic [4:0] n;
        n = nr + 5'h1;
        host.in_tok(slow);
        rsp(n, c);
    endtask
    task automatic rst();
        @(negedge CLK);
        RST_N = 1'b0;
        repeat (2) @(negedge CLK);
        RST_N = 1'b1;
    endtask
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [5:0] al [7];
        al = '{6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h17, 6'h20};
        foreach (al[i]) rd(al[i], 8'h00);
        done("reset");
    endtask
    // two queued packets, each flush drops exactly one
    task automatic t_flush();
        rst();
        wr(uec_pkg::A_IN_H, 8'h80);
        wr(uec_pkg::A_IN_L, 8'h01);
        rd(uec_pkg::A_IN_L, 8'h02);
        wr(uec_pkg::A_IN_L, 8'h01);
        rd(uec_pkg::A_IN_L, 8'h03);
        wr(uec_pkg::A_IN_L, 8'h08);
        rd(uec_pkg::A_IN_L, 8'h02);
        wr(uec_pkg::A_IN_L, 8'h08);
        rd(uec_pkg::A_IN_L, 8'h00);
        tok(uec_pkg::R_NAK, 0);
        done("flush");
    endtask
    task automatic t_underrun();
        rst();
        tok(uec_pkg::R_NAK, 3);
        rd(uec_pkg::A_IN_L, 8'h04);
        wr(uec_pkg::A_IN_L, 8'h00);
        rd(uec_pkg::A_IN_L, 8'h00);
        wr(uec_pkg::A_IN_H, 8'h40);
        rd(uec_pkg::A_IN_H, 8'h40);
        tok(uec_pkg::R_ZLP, 0);
        rd(uec_pkg::A_IN_L, 8'h04);
        done("underrun");
    endtask
    // unacked packet keeps the toggle unless forcing is on
    task automatic t_toggle();
        rst();
        wr(uec_pkg::A_IN_L, 8'h01);
        tok(uec_pkg::R_DATA, 0);
        host.tx_end(1'b0);
        rd(uec_pkg::A_IN_L, 8'h00);
        wr(uec_pkg::A_IN_L, 8'h01);
        tok(uec_pkg::R_DATA, 1);
        chk("toggle", 8'h00, {7'h0, rt});
        host.tx_end(1'b1);
        wr(uec_pkg::A_IN_L, 8'h01);
        tok(uec_pkg::R_DATA, 0);
        chk("toggle", 8'h01, {7'h0, rt});
        wr(uec_pkg::A_IN_H, 8'h08);
        host.tx_end(1'b0);
        wr(uec_pkg::A_IN_L, 8'h01);
        tok(uec_pkg::R_DATA, 0);
        chk("toggle", 8'h00, {7'h0, rt});
        done("toggle");
    endtask
    task automatic t_defer();
        rst();
        wr(uec_pkg::A_IN_H, 8'h41);
        wr(uec_pkg::A_IN_L, 8'h01);
        rd(uec_pkg::A_IN_L, 8'h02);
        tok(uec_pkg::R_ZLP, 0);
        host.sof();
        rd(uec_pkg::A_IN_L, 8'h07);
        tok(uec_pkg::R_DATA, 0);
        done("defer");
    endtask
    task automatic t_stall();
        rst();
        wr(uec_pkg::A_IN_L, 8'h10);
        tok(uec_pkg::R_STALL, 0);
        rd(uec_pkg::A_IN_L, 8'h30);
        wr(uec_pkg::A_IN_L, 8'h10);
        rd(uec_pkg::A_IN_L, 8'h10);
        done("stall");
    endtask
    // single buffer refuses the second packet, double buffer takes it
    task automatic t_out();
        rst();
        host.out_pkt(10'h105, 1'b0);
        rsp(5'h1, uec_pkg::R_ACK);
        rd(uec_pkg::A_OUT_L, 8'h03);
        rd(uec_pkg::A_CNT_L, 8'h05);
        rd(uec_pkg::A_CNT_H, 8'h01);
        host.out_pkt(10'h3ff, 1'b0);
        rsp(5'h2, uec_pkg::R_NAK);
        rd(uec_pkg::A_OUT_L, 8'h07);
        rd(uec_pkg::A_CNT_L, 8'h05);
        rst();
        wr(uec_pkg::A_OUT_H, 8'h80);
        host.out_pkt(10'h0ff, 1'b0);
        rd(uec_pkg::A_OUT_L, 8'h01);
        rd(uec_pkg::A_CNT_L, 8'hff);
        host.out_pkt(10'h2aa, 1'b0);
        rsp(5'h2, uec_pkg::R_ACK);
        rd(uec_pkg::A_OUT_L, 8'h03);
        rd(uec_pkg::A_CNT_H, 8'h02);
        // release one packet, then flush the other
        wr(uec_pkg::A_OUT_L, 8'h00);
        rd(uec_pkg::A_OUT_L, 8'h01);
        wr(uec_pkg::A_OUT_L, 8'h10);
        rd(uec_pkg::A_OUT_L, 8'h00);
        wr(uec_pkg::A_OUT_L, 8'h20);
        host.out_pkt(10'h001, 1'b0);
        rsp(5'h3, uec_pkg::R_STALL);
        rd(uec_pkg::A_OUT_L, 8'h60);
        done("out");
    endtask
    // iso OUT: bad packet flagged, no handshake sent
    task automatic t_out_data_error_flag();
        rst();
        wr(uec_pkg::A_OUT_H, 8'h40);
        rd(uec_pkg::A_OUT_H, 8'h40);
        host.out_pkt(10'h010, 1'b1);
        rsp(5'h0, 3'h0);
        rd(uec_pkg::A_OUT_L, 8'h0b);
        done("out_data_error_flag");
    endtask
    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    initial begin
        RST_N = 1'b0;
        FW_REQ = '0;
        error_cnt = 0;
        comparisons = 0;
        repeat (20) @(negedge CLK);
        RST_N = 1'b1;
        t_reset();
        t_flush();
        t_underrun();
        t_toggle();
        t_defer();
        t_stall();
        t_out();
        t_out_data_error_flag();
        finish_test();
    end
    // the scenarios need about three hundred and fifty cycles
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        finish_test();
    end
endmodule
